// ===== i2c_abort_dma_defines.svh
// Register addresses, field positions, reset values for the abort/DMA block
`ifndef I2C_ABORT_DMA_DEFINES_SVH
`define I2C_ABORT_DMA_DEFINES_SVH

`define DMA_CR_ADDR 32'h5000_1388
`define TX_WM_ADDR 32'h5000_138C
`define RX_WM_ADDR 32'h5000_1390
`define ABORT_SRC_ADDR 32'h5000_13A0
`define INT_STAT_ADDR 32'h5000_13A4
`define INT_MASK_ADDR 32'h5000_13A8

`define SEVEN_BIT_BIT 0
`define TEN_FIRST_BIT 1
`define TEN_SECOND_BIT 2
`define DATA_BYTE_BIT 3
`define GCALL_BIT 4

`define RX_DMA_EN_BIT 0
`define TX_DMA_EN_BIT 1

`define INT_ABORT_BIT 0
`define INT_FLUSH_BIT 1

`define WM_MSB 4
`define ABORT_MSB 4
`define DATA_W 16

`define DMA_CR_RST 2'h0
`define WM_RST 5'h00
`define ABORT_RST 5'h00
`define INT_RST 2'h0

`endif

// ===== i2c_abort_dma_pkg.sv
// Types shared by the abort-flag and DMA request block
package i2c_abort_dma_pkg;
	typedef logic [4:0] abort_flags_t;
	typedef logic [4:0] watermark_t;
	typedef logic [1:0] int_bits_t;
	typedef logic [15:0] reg_data_t;
endpackage

// ===== i2c_abort_dma.sv
// Transmit-abort cause flags and FIFO-level DMA request logic
// Function
// - Master general call with no acknowledge sets abort flag bit 4.
// - Master-only data byte not acknowledged after acked address sets bit 3.
// - Ten-bit master, second address byte unacknowledged sets bit 2.
// - Ten-bit master, first address byte unacknowledged sets bit 1.
// - Seven-bit master, address unacknowledged sets bit 0.
// - Transmit DMA enable, read-write bit 1, resets to 0.
// - Receive DMA enable, read-write bit 0, resets to 0.
// - Transmit request while enabled and tx level at or below watermark.
// - Receive request while enabled and rx level at least watermark plus one.
// - Slave read with stale tx data raises abort interrupt and flushes.
//
// Chosen here: the strobed register port.
`include "i2c_abort_dma_defines.svh"

module i2c_abort_dma
	import i2c_abort_dma_pkg::*;
#(
	parameter int LVL_W = 6
) (
	input wire logic clk_sys,
	input wire logic rst,
	input wire logic [31:0] addr,
	input wire logic [15:0] wdata,
	input wire logic wr_en,
	input wire logic rd_en,
	output reg_data_t rdata,
	input wire logic master_mode,
	input wire logic ten_bit_mode,
	input wire logic addr_noack,
	input wire logic second_addr_byte,
	input wire logic data_noack,
	input wire logic gcall_noack,
	input wire logic slave_read_req,
	input wire logic [LVL_W-1:0] tx_fifo_level,
	input wire logic [LVL_W-1:0] rx_fifo_level,
	output logic dma_tx_req,
	output logic dma_rx_req,
	output logic tx_flush,
	output logic transmit_abort_interrupt,
	output logic irq
);

	logic tx_dma_enable;
	logic rx_dma_enable;
	watermark_t tx_watermark_level;
	watermark_t rx_watermark_level;
	abort_flags_t abort_flags;
	abort_flags_t abort_set;
	int_bits_t int_status;
	int_bits_t int_mask;
	int_bits_t int_set;
	logic flush_evt;
	logic abort_evt;

	// Cause decode, shared by flag update and abort pulse
	function automatic abort_flags_t abort_causes(
		input logic master,
		input logic ten,
		input logic a_nack,
		input logic second,
		input logic d_nack,
		input logic g_nack
	);
		abort_flags_t c;
		c = '0;
		c[`SEVEN_BIT_BIT] = master & ~ten & a_nack;
		c[`TEN_FIRST_BIT] = master & ten & a_nack & ~second;
		c[`TEN_SECOND_BIT] = master & ten & a_nack & second;
		c[`DATA_BYTE_BIT] = master & d_nack;
		c[`GCALL_BIT] = master & g_nack;
		return c;
	endfunction

	function automatic logic hit(input logic [31:0] a, input logic [31:0] r);
		return a == r;
	endfunction

	function automatic logic [LVL_W-1:0] widen(input watermark_t w);
		return LVL_W'(w);
	endfunction

	assign abort_set = abort_causes(master_mode, ten_bit_mode, addr_noack,
		second_addr_byte, data_noack, gcall_noack);
	// stale data at a slave read
	assign flush_evt = slave_read_req & (tx_fifo_level != '0);
	assign abort_evt = (|abort_set) | flush_evt;
	assign int_set = {flush_evt, abort_evt};

	always_ff @(posedge clk_sys or posedge rst) begin
		if (rst) begin
			tx_dma_enable <= 1'b0;
		end else if (wr_en && hit(addr, `DMA_CR_ADDR)) begin
			tx_dma_enable <= wdata[`TX_DMA_EN_BIT];
		end
	end

	always_ff @(posedge clk_sys or posedge rst) begin
		if (rst) begin
			rx_dma_enable <= 1'b0;
		end else if (wr_en && hit(addr, `DMA_CR_ADDR)) begin
			rx_dma_enable <= wdata[`RX_DMA_EN_BIT];
		end
	end

	always_ff @(posedge clk_sys or posedge rst) begin
		if (rst) begin
			tx_watermark_level <= `WM_RST;
		end else if (wr_en && hit(addr, `TX_WM_ADDR)) begin
			tx_watermark_level <= wdata[`WM_MSB:0];
		end
	end

	always_ff @(posedge clk_sys or posedge rst) begin
		if (rst) begin
			rx_watermark_level <= `WM_RST;
		end else if (wr_en && hit(addr, `RX_WM_ADDR)) begin
			rx_watermark_level <= wdata[`WM_MSB:0];
		end
	end

	// Sticky cause flags; a new cause beats a same-cycle clear
	always_ff @(posedge clk_sys or posedge rst) begin
		if (rst) begin
			abort_flags <= `ABORT_RST;
		end else if (wr_en && hit(addr, `ABORT_SRC_ADDR)) begin
			abort_flags <= (abort_flags & ~wdata[`ABORT_MSB:0]) | abort_set;
		end else begin
			abort_flags <= abort_flags | abort_set;
		end
	end

	always_ff @(posedge clk_sys or posedge rst) begin
		if (rst) begin
			int_status <= `INT_RST;
		end else if (wr_en && hit(addr, `INT_STAT_ADDR)) begin
			int_status <= (int_status & ~wdata[1:0]) | int_set;
		end else begin
			int_status <= int_status | int_set;
		end
	end

	always_ff @(posedge clk_sys or posedge rst) begin
		if (rst) begin
			int_mask <= `INT_RST;
		end else if (wr_en && hit(addr, `INT_MASK_ADDR)) begin
			int_mask <= wdata[1:0];
		end
	end

	// Registered so the request never glitches on FIFO count ripple
	// tx at or below watermark
	always_ff @(posedge clk_sys or posedge rst) begin
		if (rst) begin
			dma_tx_req <= 1'b0;
		end else begin
			dma_tx_req <= tx_dma_enable && (tx_fifo_level <= widen(tx_watermark_level));
		end
	end

	// Field plus one, so a zero field requests on a single entry
	// rx above watermark
	always_ff @(posedge clk_sys or posedge rst) begin
		if (rst) begin
			dma_rx_req <= 1'b0;
		end else begin
			dma_rx_req <= rx_dma_enable && (rx_fifo_level > widen(rx_watermark_level));
		end
	end

	always_ff @(posedge clk_sys or posedge rst) begin
		if (rst) begin
			tx_flush <= 1'b0;
			transmit_abort_interrupt <= 1'b0;
		end else begin
			tx_flush <= flush_evt;
			transmit_abort_interrupt <= abort_evt;
		end
	end

	always_ff @(posedge clk_sys or posedge rst) begin
		if (rst) begin
			irq <= 1'b0;
		end else begin
			irq <= |(int_status & int_mask);
		end
	end

	// register read back
	// Unmapped addresses read as zero
	always_ff @(posedge clk_sys or posedge rst) begin
		if (rst) begin
			rdata <= '0;
		end else if (rd_en) begin
			if (hit(addr, `DMA_CR_ADDR)) begin
				rdata <= {14'h0000, tx_dma_enable, rx_dma_enable};
			end else if (hit(addr, `TX_WM_ADDR)) begin
				rdata <= {11'h000, tx_watermark_level};
			end else if (hit(addr, `RX_WM_ADDR)) begin
				rdata <= {11'h000, rx_watermark_level};
			end else if (hit(addr, `ABORT_SRC_ADDR)) begin
				rdata <= {11'h000, abort_flags};
			end else if (hit(addr, `INT_STAT_ADDR)) begin
				rdata <= {14'h0000, int_status};
			end else if (hit(addr, `INT_MASK_ADDR)) begin
				rdata <= {14'h0000, int_mask};
			end else begin
				rdata <= '0;
			end
		end else begin
			rdata <= '0;
		end
	end

	default clocking cb @(posedge clk_sys);
	endclocking
	default disable iff (rst);

	// Abort cause flags
	gcall_flag_a: assert property (master_mode && gcall_noack |=> abort_flags[4])
		else $error("general call flag not set");

	flags_sticky_a: assert property (
		!(wr_en && addr == `ABORT_SRC_ADDR)
		|=> (abort_flags & $past(abort_flags)) == $past(abort_flags))
		else $error("abort flag lost without clear");

	quiet_abort_a: assert property (
		!master_mode && !slave_read_req |=> !transmit_abort_interrupt)
		else $error("abort pulse without cause");

	data_flag_a: assert property (
		!master_mode && data_noack && !abort_flags[3] |=> !abort_flags[3])
		else $error("data flag set outside master mode");

	data_set_a: assert property (master_mode && data_noack |=> abort_flags[3])
		else $error("data flag not set");

	ten_second_a: assert property (
		master_mode && ten_bit_mode && addr_noack && second_addr_byte |=> abort_flags[2])
		else $error("ten-bit second byte flag not set");

	ten_only_a: assert property (
		!ten_bit_mode && abort_flags[2:1] == 2'b00 |=> abort_flags[2:1] == 2'b00)
		else $error("ten-bit flag set in seven-bit mode");

	ten_first_a: assert property (
		master_mode && ten_bit_mode && addr_noack && !second_addr_byte |=> abort_flags[1])
		else $error("ten-bit first byte flag not set");

	slave_quiet_a: assert property (
		!master_mode && abort_flags == 5'h00 |=> abort_flags == 5'h00)
		else $error("abort flag set outside master mode");

	seven_addr_a: assert property (
		master_mode && !ten_bit_mode && addr_noack |=> abort_flags[0] && transmit_abort_interrupt)
		else $error("seven-bit flag or abort pulse missing");

	seven_only_a: assert property (ten_bit_mode && !abort_flags[0] |=> !abort_flags[0])
		else $error("seven-bit flag set in ten-bit mode");

	flag_clear_a: assert property (
		wr_en && addr == `ABORT_SRC_ADDR && wdata[0]
		&& !(master_mode && !ten_bit_mode && addr_noack) |=> !abort_flags[0])
		else $error("seven-bit flag not cleared");

	// DMA channel enables and requests
	tx_enable_a: assert property (
		wr_en && addr == `DMA_CR_ADDR
		|=> tx_dma_enable == $past(wdata[1]) && rx_dma_enable == $past(wdata[0]))
		else $error("enable bits not written");

	tx_disabled_a: assert property (!tx_dma_enable |=> !dma_tx_req)
		else $error("tx request while disabled");

	rx_disabled_a: assert property (!rx_dma_enable |=> !dma_rx_req)
		else $error("rx request while disabled");

	tx_request_a: assert property (
		tx_dma_enable && (tx_fifo_level <= LVL_W'(tx_watermark_level)) |=> dma_tx_req)
		else $error("tx request missing");

	tx_idle_a: assert property (
		!(tx_dma_enable && (tx_fifo_level <= LVL_W'(tx_watermark_level)))
		|=> !dma_tx_req)
		else $error("tx request above watermark");

	tx_wm_write_a: assert property (
		wr_en && addr == `TX_WM_ADDR |=> tx_watermark_level == $past(wdata[`WM_MSB:0]))
		else $error("tx watermark not written");

	rx_request_a: assert property (
		rx_dma_enable && rx_fifo_level >= LVL_W'(rx_watermark_level) + 1'b1
		|=> dma_rx_req)
		else $error("rx request missing");

	rx_idle_a: assert property (
		!(rx_dma_enable && rx_fifo_level >= LVL_W'(rx_watermark_level) + 1'b1)
		|=> !dma_rx_req)
		else $error("rx request below watermark");

	rx_wm_write_a: assert property (
		wr_en && addr == `RX_WM_ADDR |=> rx_watermark_level == $past(wdata[`WM_MSB:0]))
		else $error("rx watermark not written");

	// Slave flush, interrupt status and read port
	slave_flush_a: assert property (
		slave_read_req && tx_fifo_level != '0
		|=> tx_flush && transmit_abort_interrupt && int_status[1])
		else $error("flush or abort pulse missing");

	no_flush_a: assert property (
		!(slave_read_req && tx_fifo_level != '0) |=> !tx_flush)
		else $error("flush without stale data");

	flush_abort_a: assert property (tx_flush |-> transmit_abort_interrupt)
		else $error("flush without abort pulse");

	status_sticky_a: assert property (
		int_status[1] && !(wr_en && addr == `INT_STAT_ADDR) |=> int_status[1])
		else $error("flush status lost without clear");

	irq_level_a: assert property ((int_status & int_mask) != '0 |=> irq)
		else $error("irq not raised");

	irq_low_a: assert property ((int_status & int_mask) == 2'b00 |=> !irq)
		else $error("irq raised without unmasked status");

	mask_write_a: assert property (
		wr_en && addr == `INT_MASK_ADDR |=> int_mask == $past(wdata[1:0]))
		else $error("interrupt mask not written");

	read_idle_a: assert property (!rd_en |=> rdata == 16'h0000)
		else $error("read data outside read cycle");

	tx_req_c: cover property (dma_tx_req ##1 !dma_tx_req);
	rx_req_c: cover property (dma_rx_req && rx_watermark_level == 5'h00);
	flush_c: cover property (tx_flush ##1 irq);
	clear_c: cover property (wr_en && addr == `ABORT_SRC_ADDR && (|abort_set));
	data_c: cover property (master_mode && data_noack ##1 transmit_abort_interrupt);

endmodule

// ===== dma_partner.sv
// Model of the DMA controller servicing the FIFOs
module dma_partner (
	input wire logic clk_sys,
	input wire logic rst,
	input wire logic svc,
	input wire logic ld,
	input wire logic [5:0] tx_ld,
	input wire logic [5:0] rx_ld,
	input wire logic dma_tx_req,
	input wire logic dma_rx_req,
	output logic [5:0] tx_fifo_level,
	output logic [5:0] rx_fifo_level
);
	timeunit 1ns;
	timeprecision 100ps;
	// fill and drain
	// Registered requests lag, so one extra entry may move
	always_ff @(posedge clk_sys or posedge rst) begin
		if (rst) begin
			tx_fifo_level <= 6'h00;
			rx_fifo_level <= 6'h00;
		end else if (ld) begin
			tx_fifo_level <= tx_ld;
			rx_fifo_level <= rx_ld;
		end else if (svc) begin
			if (dma_tx_req)
				tx_fifo_level <= tx_fifo_level + 6'h01;
			if (dma_rx_req && rx_fifo_level != 6'h00)
				rx_fifo_level <= rx_fifo_level - 6'h01;
		end
	end
endmodule

// ===== test_i2c_abort_dma.sv
// Self-checking bench for the abort flag and DMA request block
`include "i2c_abort_dma_defines.svh"
module test_i2c_abort_dma
	import i2c_abort_dma_pkg::*;
;
	timeunit 1ns;
	timeprecision 100ps;
	logic clk_sys = 0, rst = 1, wr_en = 0, rd_en = 0, svc = 0, ld = 0;
	logic master_mode = 0, ten_bit_mode = 0, addr_noack = 0, second_addr_byte = 0;
	logic data_noack = 0, gcall_noack = 0, slave_read_req = 0;
	logic [31:0] addr = 32'h0;
	logic [15:0] wdata = 16'h0;
	logic [5:0] tx_ld = 6'h00, rx_ld = 6'h00, tx_fifo_level, rx_fifo_level;
	reg_data_t rdata;
	logic dma_tx_req, dma_rx_req, tx_flush, transmit_abort_interrupt, irq;
	int error_cnt = 0, cmp_count = 0, cycles = 0;
	logic [4:0] tab [5] = '{5'h04, 5'h05, 5'h07, 5'h08, 5'h10};

	i2c_abort_dma #(.LVL_W(6)) i_i2c_abort_dma (.clk_sys(clk_sys), .rst(rst), .addr(addr),
		.wdata(wdata), .wr_en(wr_en), .rd_en(rd_en), .rdata(rdata), .master_mode(master_mode),
		.ten_bit_mode(ten_bit_mode), .addr_noack(addr_noack),
		.second_addr_byte(second_addr_byte), .data_noack(data_noack),
		.gcall_noack(gcall_noack), .slave_read_req(slave_read_req),
		.tx_fifo_level(tx_fifo_level), .rx_fifo_level(rx_fifo_level), .dma_tx_req(dma_tx_req),
		.dma_rx_req(dma_rx_req), .tx_flush(tx_flush),
		.transmit_abort_interrupt(transmit_abort_interrupt), .irq(irq));
	dma_partner i_dma_partner (.clk_sys(clk_sys), .rst(rst), .svc(svc), .ld(ld), .tx_ld(tx_ld),
		.rx_ld(rx_ld), .dma_tx_req(dma_tx_req), .dma_rx_req(dma_rx_req),
		.tx_fifo_level(tx_fifo_level), .rx_fifo_level(rx_fifo_level));

	initial begin
		forever #5 clk_sys = ~clk_sys;
	end

	task automatic report_and_stop();
		if (error_cnt == 0 && cmp_count > 0)
			$display("No errors found");
		else
			$display("Errors were found");
		$finish;
	endtask

	// Hang guard, tests need well under this
	always @(posedge clk_sys) begin
		cycles++;
		if (cycles == 3000) begin
			error_cnt++;
			report_and_stop();
		end
	end

	task automatic chk(input reg_data_t got, input reg_data_t exp);
		cmp_count++;
		if (got !== exp) begin
			error_cnt++;
			$display("CHECK FAILED at %0t: got %h expected %h", $time, got, exp);
		end
	endtask

	task automatic wr(input logic [31:0] a, input logic [15:0] d);
		@(posedge clk_sys);
		addr <= a;
		wdata <= d;
		wr_en <= 1'b1;
		@(posedge clk_sys);
		wr_en <= 1'b0;
	endtask

	task automatic rd(input logic [31:0] a, input reg_data_t exp);
		@(posedge clk_sys);
		addr <= a;
		rd_en <= 1'b1;
		@(posedge clk_sys);
		rd_en <= 1'b0;
		#1 chk(rdata, exp);
	endtask

	// Load levels, then let the registered requests settle
	task automatic load(input logic [5:0] t, input logic [5:0] r);
		@(posedge clk_sys);
		ld <= 1'b1;
		tx_ld <= t;
		rx_ld <= r;
		@(posedge clk_sys);
		ld <= 1'b0;
		@(posedge clk_sys);
		#1;
	endtask

	// Fields: gcall, data, address, second byte, ten-bit mode
	task automatic ev(input logic [4:0] e, input logic m);
		@(posedge clk_sys);
		{gcall_noack, data_noack, addr_noack, second_addr_byte, ten_bit_mode} <= e;
		master_mode <= m;
		@(posedge clk_sys);
		{gcall_noack, data_noack, addr_noack, second_addr_byte, ten_bit_mode} <= 5'h00;
		#1 chk(16'(transmit_abort_interrupt), 16'(m));
	endtask

	task automatic flush(input logic [5:0] lvl, input logic exp);
		load(lvl, 6'h00);
		@(posedge clk_sys);
		slave_read_req <= 1'b1;
		@(posedge clk_sys);
		slave_read_req <= 1'b0;
		#1 chk(16'(tx_flush), 16'(exp));
		chk(16'(transmit_abort_interrupt), 16'(exp));
	endtask

	initial begin
		repeat (6) @(posedge clk_sys);
		rst <= 1'b0;
		rd(`DMA_CR_ADDR, 16'h0000);
		rd(`TX_WM_ADDR, 16'h0000);
		rd(`RX_WM_ADDR, 16'h0000);
		rd(32'h5000_13B0, 16'h0000);
		chk(16'(dma_tx_req), 16'h0000);
		wr(`TX_WM_ADDR, 16'h0002);
		wr(`RX_WM_ADDR, 16'h0003);
		wr(`DMA_CR_ADDR, 16'h0003);
		rd(`DMA_CR_ADDR, 16'h0003);
		rd(`RX_WM_ADDR, 16'h0003);
		load(6'h02, 6'h03);
		chk(16'(dma_tx_req), 16'h0001);
		chk(16'(dma_rx_req), 16'h0000);
		load(6'h03, 6'h04);
		chk(16'(dma_tx_req), 16'h0000);
		chk(16'(dma_rx_req), 16'h0001);
		svc <= 1'b1;
		repeat (10) @(posedge clk_sys);
		svc <= 1'b0;
		#1 chk(16'(dma_tx_req), 16'h0000);
		chk(16'(dma_rx_req), 16'h0000);
		wr(`DMA_CR_ADDR, 16'h0002);
		load(6'h00, 6'h14);
		chk(16'(dma_tx_req), 16'h0001);
		chk(16'(dma_rx_req), 16'h0000);
		svc <= 1'b1;
		repeat (6) @(posedge clk_sys);
		svc <= 1'b0;
		#1 chk(16'(dma_tx_req), 16'h0000);
		chk(16'(tx_fifo_level), 16'h0004);
		wr(`DMA_CR_ADDR, 16'h0000);
		wr(`INT_MASK_ADDR, 16'h0001);
		for (int i = 0; i < 5; i++) begin
			ev(tab[i], 1'b1);
			rd(`ABORT_SRC_ADDR, 16'(1 << i));
			wr(`ABORT_SRC_ADDR, 16'h001F);
		end
		chk(16'(irq), 16'h0001);
		ev(5'h1F, 1'b0);
		rd(`ABORT_SRC_ADDR, 16'h0000);
		wr(`INT_STAT_ADDR, 16'h0003);
		repeat (2) @(posedge clk_sys);
		#1 chk(16'(irq), 16'h0000);
		flush(6'h00, 1'b0);
		flush(6'h03, 1'b1);
		rd(`INT_STAT_ADDR, 16'h0003);
		report_and_stop();
	end
endmodule
